//--- drl_pkg.sv
package drl_pkg;
	// coprocessor register number and selects served by this block
	localparam logic [4:0] CP0_REG_DEBUG = 5'h18;
	localparam logic [2:0] SEL_RESUME = 3'h0;
	localparam logic [2:0] SEL_USER_TRACE = 3'h3;

	// field positions of the resume register as seen by a coprocessor move
	localparam int PC_HI = 31;
	localparam int PC_LO = 1;
	localparam int ISA_BIT = 0;

	// reset values
	localparam logic [31:0] UTD_RESET = 32'h0000_0000;
	localparam logic [1:0] ISA_RESET = 2'h0;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
	localparam logic [31:0] RET_RESET = 32'h0000_0000;

	// user trace record types: USER1/USER2 picked by the type select bit, NONE at reset or when trace is absent
	localparam logic [1:0] REC_TYPE_USER1 = 2'h1;
	localparam logic [1:0] REC_TYPE_USER2 = 2'h2;
	localparam logic [1:0] REC_TYPE_NONE = 2'h0;

	// read latency of a coprocessor move, in clk_sys cycles
	localparam int MOVE_READ_CYCLES = 1;

	typedef enum logic {
		DRL_RUN,
		DRL_DEBUG
	} drl_mode_t;
endpackage

//--- drl_move_if.sv
`timescale 1ns/1ps
interface drl_move_if;
	logic wr_resume;
	logic wr_trace;
	logic exc_take;
	logic [31:0] wdata;
	logic [31:0] exc_addr;
	logic [1:0] exc_isa;
	logic [31:0] resume_q;
	logic [1:0] isa_q;
	logic [31:0] next_resume;
	logic [1:0] next_isa;
	logic [31:0] trace_q;

	modport ctrl (
		output wr_resume, wr_trace, exc_take, wdata, exc_addr, exc_isa,
		input resume_q, isa_q, next_resume, next_isa, trace_q
	);
	modport resume (
		input wr_resume, exc_take, wdata, exc_addr, exc_isa,
		output resume_q, isa_q, next_resume, next_isa
	);
	modport trace (
		input wr_trace, wdata,
		output trace_q
	);
endinterface

//--- drl_resume_reg.sv
`timescale 1ns/1ps
module drl_resume_reg (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// link to the control logic
	drl_move_if.resume bus
);
	// an exception capture beats a software write in the same cycle
	always_comb begin
		bus.next_resume = bus.resume_q;
		bus.next_isa = bus.isa_q;
		if (bus.exc_take) begin
			bus.next_resume = bus.exc_addr;
			bus.next_isa = bus.exc_isa;
		end else if (bus.wr_resume) begin
			bus.next_resume = {bus.wdata[drl_pkg::PC_HI:drl_pkg::PC_LO], 1'b0};
			bus.next_isa = {1'b0, bus.wdata[drl_pkg::ISA_BIT]};
		end
	end

	// address is data, left unreset on purpose to save reset fanout
	always_ff @(posedge clk_sys) begin
		bus.resume_q <= bus.next_resume;
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			bus.isa_q <= drl_pkg::ISA_RESET;
		end else begin
			bus.isa_q <= bus.next_isa;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_sw_write;
		bus.wr_resume && !bus.exc_take;
	endsequence

	chk_write_split_pc: assert property (s_sw_write |=> bus.resume_q == {$past(bus.wdata[31:1]), 1'b0})
		else $error("resume write did not split the program counter");
	chk_write_isa_field: assert property (s_sw_write |=> bus.isa_q == {1'b0, $past(bus.wdata[0])})
		else $error("resume write did not set the mode field");
	chk_exc_capture: assert property (bus.exc_take |=> bus.resume_q == $past(bus.exc_addr))
		else $error("exception address not captured");
endmodule

//--- drl_user_trace.sv
`timescale 1ns/1ps
module drl_user_trace (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// link to the control logic
	drl_move_if.trace bus,
	// trace control
	input wire logic user_trace_type_select,
	// trace record out
	output logic rec_valid,
	output logic [1:0] rec_type,
	output logic [31:0] rec_data
);
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			bus.trace_q <= drl_pkg::UTD_RESET;
		end else if (bus.wr_trace) begin
			bus.trace_q <= bus.wdata;
		end
	end

	// back-to-back writes are not guarded: the issuing side keeps them apart
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rec_valid <= 1'b0;
			rec_type <= drl_pkg::REC_TYPE_NONE;
			rec_data <= drl_pkg::UTD_RESET;
		end else begin
			rec_valid <= bus.wr_trace;
			if (bus.wr_trace) begin
				rec_type <= user_trace_type_select ? drl_pkg::REC_TYPE_USER2 : drl_pkg::REC_TYPE_USER1;
				rec_data <= bus.wdata;
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	chk_trace_record: assert property (bus.wr_trace |=> rec_valid && rec_data == $past(bus.wdata))
		else $error("write to trace data emitted no record");
	chk_trace_type: assert property (bus.wr_trace && user_trace_type_select |=> rec_type == 2'h2)
		else $error("type select not honoured");
	chk_trace_quiet: assert property (!bus.wr_trace |=> !rec_valid)
		else $error("record without a write");
endmodule

//--- drl_debug_resume.sv
`timescale 1ns/1ps
// Summary of operation
// - resume register holds where execution continues after a debug exception
// - precise debug exception loads the address of the causing instruction
// - in a delay slot load the branch address and set the delay flag
// - debug interrupt loads the address where execution must resume
// - read returns pc bits 31..1 and mode field bit 0 in bit 0
// - write copies bits 31..1 to the pc and clears stored pc bit 0
// - write clears upper mode bit and loads lower mode bit from bit 0
// - debug return jumps to the address held in the resume register
// - resume register is 32 bits, read/write, undefined after reset
// - every write to user trace data emits one user trace record
// - record type follows the user trace type select bit
// - record carries all 32 written bits; register resets to zero
// - user trace data exists only when trace capability is configured
module drl_debug_resume #(
	parameter bit TRACE_PRESENT = 1'b1
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// coprocessor moves from the pipeline
	input wire logic coprocessor_move_to,
	input wire logic coprocessor_move_from,
	input wire logic [4:0] move_reg,
	input wire logic [2:0] move_sel,
	input wire logic [31:0] move_wdata,
	output logic move_rdata_valid,
	output logic [31:0] move_rdata,
	// debug exception entry
	input wire logic debug_exc_valid,
	input wire logic debug_exc_async,
	input wire logic debug_exc_delay_slot,
	input wire logic [31:0] debug_exc_pc,
	input wire logic [31:0] debug_exc_branch_pc,
	input wire logic [31:0] debug_exc_resume_pc,
	input wire logic [1:0] debug_exc_isa,
	// debug return
	input wire logic debug_return_instruction,
	output logic return_valid,
	output logic [31:0] return_target,
	output logic [1:0] return_isa,
	// status
	output logic debug_branch_delay_flag,
	output logic [1:0] instruction_set_mode_field,
	output logic in_debug_mode,
	// trace
	input wire logic user_trace_type_select,
	output logic trace_rec_valid,
	output logic [1:0] trace_rec_type,
	output logic [31:0] trace_rec_data
);
	drl_move_if bus ();

	drl_pkg::drl_mode_t mode;
	drl_pkg::drl_mode_t next_mode;
	logic hit_resume;
	logic hit_trace;
	logic return_take;
	logic [31:0] next_rdata;

	function automatic logic drl_hit(input logic [4:0] r, input logic [2:0] s, input logic [2:0] want);
		drl_hit = (r == drl_pkg::CP0_REG_DEBUG) && (s == want);
	endfunction

	// register decode
	assign hit_resume = drl_hit(move_reg, move_sel, drl_pkg::SEL_RESUME);
	assign hit_trace = drl_hit(move_reg, move_sel, drl_pkg::SEL_USER_TRACE) && TRACE_PRESENT;

	assign bus.wdata = move_wdata;
	assign bus.wr_resume = coprocessor_move_to && hit_resume;
	assign bus.wr_trace = coprocessor_move_to && hit_trace;

	// exception address selection
	assign bus.exc_take = debug_exc_valid;
	assign bus.exc_isa = debug_exc_isa;
	always_comb begin
		if (debug_exc_async) begin
			bus.exc_addr = debug_exc_resume_pc;
		end else if (debug_exc_delay_slot) begin
			bus.exc_addr = debug_exc_branch_pc;
		end else begin
			bus.exc_addr = debug_exc_pc;
		end
	end

	// branch delay flag only describes precise exceptions
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			debug_branch_delay_flag <= 1'b0;
		end else if (debug_exc_valid) begin
			debug_branch_delay_flag <= !debug_exc_async && debug_exc_delay_slot;
		end
	end

	// read mux
	always_comb begin
		next_rdata = drl_pkg::RDATA_RESET;
		if (hit_resume) begin
			next_rdata = {bus.resume_q[drl_pkg::PC_HI:drl_pkg::PC_LO], bus.isa_q[0]};
		end else if (hit_trace) begin
			next_rdata = bus.trace_q;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			move_rdata_valid <= 1'b0;
			move_rdata <= drl_pkg::RDATA_RESET;
		end else begin
			move_rdata_valid <= coprocessor_move_from;
			if (coprocessor_move_from) begin
				move_rdata <= next_rdata;
			end
		end
	end

	// debug mode tracking; a new exception outranks a return in the same cycle
	assign return_take = debug_return_instruction && (mode == drl_pkg::DRL_DEBUG) && !debug_exc_valid;

	always_comb begin
		next_mode = mode;
		case (mode)
			drl_pkg::DRL_RUN: begin
				if (debug_exc_valid) begin
					next_mode = drl_pkg::DRL_DEBUG;
				end
			end
			drl_pkg::DRL_DEBUG: begin
				if (return_take) begin
					next_mode = drl_pkg::DRL_RUN;
				end
			end
			default: begin
				next_mode = drl_pkg::DRL_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			mode <= drl_pkg::DRL_RUN;
		end else begin
			mode <= next_mode;
		end
	end

	assign in_debug_mode = (mode == drl_pkg::DRL_DEBUG);

	// return target taken from the next value so a same-cycle write is honoured
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			return_valid <= 1'b0;
			return_target <= drl_pkg::RET_RESET;
			return_isa <= drl_pkg::ISA_RESET;
		end else begin
			return_valid <= return_take;
			if (return_take) begin
				return_target <= bus.next_resume;
				return_isa <= bus.next_isa;
			end
		end
	end

	assign instruction_set_mode_field = bus.isa_q;

	drl_resume_reg u_resume (
		.clk_sys(clk_sys),
		.reset(reset),
		.bus(bus.resume)
	);

	generate
		if (TRACE_PRESENT) begin : g_trace
			drl_user_trace u_trace (
				.clk_sys(clk_sys),
				.reset(reset),
				.bus(bus.trace),
				.user_trace_type_select(user_trace_type_select),
				.rec_valid(trace_rec_valid),
				.rec_type(trace_rec_type),
				.rec_data(trace_rec_data)
			);
		end else begin : g_no_trace
			// absent register reads as zero and never emits
			assign bus.trace_q = drl_pkg::UTD_RESET;
			assign trace_rec_valid = 1'b0;
			assign trace_rec_type = drl_pkg::REC_TYPE_NONE;
			assign trace_rec_data = drl_pkg::UTD_RESET;
		end
	endgenerate

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_precise_exc;
		debug_exc_valid && !debug_exc_async;
	endsequence

	sequence s_write_then_return;
		bus.wr_resume && !debug_exc_valid ##1 !bus.wr_resume && !debug_exc_valid
			##1 return_take && !bus.wr_resume;
	endsequence

	chk_precise_address: assert property ((s_precise_exc and !debug_exc_delay_slot) |=>
		bus.resume_q == $past(debug_exc_pc) && !debug_branch_delay_flag)
		else $error("precise exception address wrong");
	chk_delay_slot_address: assert property ((s_precise_exc and debug_exc_delay_slot) |=>
		bus.resume_q == $past(debug_exc_branch_pc) && debug_branch_delay_flag)
		else $error("delay slot capture wrong");
	chk_async_address: assert property (debug_exc_valid && debug_exc_async |=>
		bus.resume_q == $past(debug_exc_resume_pc) && !debug_branch_delay_flag)
		else $error("debug interrupt resume address wrong");
	chk_read_format: assert property (coprocessor_move_from && hit_resume |=>
		move_rdata_valid && move_rdata == {$past(bus.resume_q[31:1]), $past(bus.isa_q[0])})
		else $error("resume read format wrong");
	chk_return_target: assert property (return_take && !bus.wr_resume |=>
		return_valid && return_target == $past(bus.resume_q) && !in_debug_mode)
		else $error("debug return target wrong");
	chk_return_after_write: assert property (s_write_then_return |=>
		return_target == {$past(move_wdata[31:1], 3), 1'b0} && return_isa == {1'b0, $past(move_wdata[0], 3)})
		else $error("return missed a preceding write");
	chk_return_same_cycle: assert property (return_take && bus.wr_resume |=>
		return_target == {$past(move_wdata[31:1]), 1'b0})
		else $error("return missed a same-cycle write");
	chk_trace_absent: assert property (!TRACE_PRESENT |-> !trace_rec_valid)
		else $error("record emitted without trace capability");
	chk_no_stray_return: assert property (!return_take |=> !return_valid)
		else $error("return pulse without a taken return");

	// mode state and capture on entry
	sequence s_exc_taken;
		debug_exc_valid;
	endsequence

	sequence s_return_now;
		return_take;
	endsequence

	sequence s_read_now;
		coprocessor_move_from;
	endsequence

	chk_exc_enters_debug: assert property (s_exc_taken |=>
		in_debug_mode)
		else $error("exception did not enter debug mode");
	chk_exc_mode_field: assert property (s_exc_taken |=>
		instruction_set_mode_field == $past(debug_exc_isa))
		else $error("exception did not capture the mode field");
	chk_flag_hold: assert property (!debug_exc_valid |=>
		$stable(debug_branch_delay_flag))
		else $error("delay flag changed without an exception");
	chk_stay_debug: assert property (in_debug_mode && !return_take |=>
		in_debug_mode)
		else $error("debug mode left without a return");
	chk_stay_run: assert property (!in_debug_mode && !debug_exc_valid |=>
		!in_debug_mode)
		else $error("debug mode entered without an exception");

	// read port and foreign writes
	chk_read_pulse: assert property (s_read_now |=>
		move_rdata_valid)
		else $error("read gave no valid pulse");
	chk_read_quiet: assert property (!coprocessor_move_from |=>
		!move_rdata_valid && $stable(move_rdata))
		else $error("read data moved without a read");
	chk_trace_read: assert property ((s_read_now and hit_trace) |=>
		move_rdata == $past(bus.trace_q))
		else $error("trace data read wrong");
	chk_unmapped_read: assert property (coprocessor_move_from && !hit_resume && !hit_trace |=>
		move_rdata == drl_pkg::RDATA_RESET)
		else $error("unmapped read not zero");
	chk_foreign_write: assert property (coprocessor_move_to && !hit_resume && !debug_exc_valid |=>
		$stable(bus.isa_q))
		else $error("mode field changed by a foreign write");

	// return port
	chk_return_pulse: assert property (s_return_now |=>
		return_valid)
		else $error("taken return gave no pulse");
	chk_return_ignored: assert property (debug_return_instruction && !in_debug_mode |=>
		!return_valid)
		else $error("return honoured outside debug mode");
	chk_return_hold: assert property (!return_take |=>
		$stable(return_target) && $stable(return_isa))
		else $error("return target moved without a return");
	chk_return_isa: assert property ((s_return_now and !bus.wr_resume) |=>
		return_isa == $past(bus.isa_q))
		else $error("return mode field wrong");
	chk_return_isa_same: assert property ((s_return_now and bus.wr_resume) |=>
		return_isa == {1'b0, $past(move_wdata[0])})
		else $error("return mode missed a same-cycle write");

	// trace port
	chk_trace_out: assert property (bus.wr_trace |=>
		trace_rec_valid && trace_rec_data == $past(move_wdata))
		else $error("trace record data wrong");
	chk_trace_type_one: assert property (bus.wr_trace && !user_trace_type_select |=>
		trace_rec_type == drl_pkg::REC_TYPE_USER1)
		else $error("record type one not honoured");
	chk_trace_type_two: assert property (bus.wr_trace && user_trace_type_select |=>
		trace_rec_type == drl_pkg::REC_TYPE_USER2)
		else $error("record type two not honoured");
endmodule

//--- drl_pipe_model.sv
`timescale 1ns/1ps
module drl_pipe_model (
	// clock
	input wire logic clk_sys,
	// coprocessor moves and debug return
	output logic move_to,
	output logic move_from,
	output logic [2:0] move_sel,
	output logic [31:0] move_wdata,
	output logic ret,
	// debug exception entry
	output logic exc_valid,
	output logic exc_async,
	output logic exc_slot,
	output logic [31:0] exc_pc,
	output logic [31:0] exc_bpc,
	output logic [31:0] exc_rpc,
	output logic [1:0] exc_isa
);
	initial begin
		{move_to, move_from, ret, exc_valid, exc_async, exc_slot} = 6'h00;
		{move_sel, exc_isa} = 5'h00;
		{move_wdata, exc_pc, exc_bpc, exc_rpc} = 128'h0;
	end

	// one move per call; the next call starts a cycle later, so trace writes never land back to back
	task automatic mv(input logic to, input logic from, input logic [2:0] sel, input logic [31:0] d, input logic r);
		@(posedge clk_sys);
		move_to <= to;
		move_from <= from;
		move_sel <= sel;
		move_wdata <= d;
		ret <= r;
		@(posedge clk_sys);
		move_to <= 1'b0;
		move_from <= 1'b0;
		ret <= 1'b0;
		// released data must not keep looking valid
		move_wdata <= ~d;
	endtask

	task automatic exc(input logic a, input logic s, input logic [31:0] pc, input logic [1:0] isa);
		@(posedge clk_sys);
		exc_valid <= 1'b1;
		exc_async <= a;
		exc_slot <= s;
		exc_pc <= pc;
		exc_bpc <= pc + 32'h0000_0010;
		exc_rpc <= pc + 32'h0000_0040;
		exc_isa <= isa;
		@(posedge clk_sys);
		exc_valid <= 1'b0;
		exc_pc <= ~exc_pc;
		exc_bpc <= ~exc_bpc;
		exc_rpc <= ~exc_rpc;
	endtask
endmodule

//--- drl_debug_resume_tb.sv
`timescale 1ns/1ps
module drl_debug_resume_tb;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic uts = 1'b0;
	logic [4:0] mreg = drl_pkg::CP0_REG_DEBUG;
	logic mt, mf, rt, ev, ea, es, rv, tv, bd, dm, pv;
	logic [2:0] sel;
	logic [31:0] wd, pc, bpc, rpc, rdata, tgt, pd;
	logic [1:0] eisa, risa, fisa, pt;
	logic [31:0] seed = 32'h0000_0013;
	int mismatches = 0;
	int compares = 0;
	int cycles = 0;

	always #50 clk_sys = ~clk_sys;

	drl_pipe_model pipe (.clk_sys(clk_sys), .move_to(mt), .move_from(mf), .move_sel(sel), .move_wdata(wd),
		.ret(rt), .exc_valid(ev), .exc_async(ea), .exc_slot(es), .exc_pc(pc), .exc_bpc(bpc),
		.exc_rpc(rpc), .exc_isa(eisa));

	drl_debug_resume dut (.clk_sys(clk_sys), .reset(reset), .coprocessor_move_to(mt),
		.coprocessor_move_from(mf), .move_reg(mreg), .move_sel(sel), .move_wdata(wd),
		.move_rdata_valid(rv), .move_rdata(rdata), .debug_exc_valid(ev), .debug_exc_async(ea),
		.debug_exc_delay_slot(es), .debug_exc_pc(pc), .debug_exc_branch_pc(bpc),
		.debug_exc_resume_pc(rpc), .debug_exc_isa(eisa), .debug_return_instruction(rt),
		.return_valid(tv), .return_target(tgt), .return_isa(risa), .debug_branch_delay_flag(bd),
		.instruction_set_mode_field(fisa), .in_debug_mode(dm), .user_trace_type_select(uts),
		.trace_rec_valid(pv), .trace_rec_type(pt), .trace_rec_data(pd));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// kind 0 precise, 1 delay slot, 2 debug interrupt
	function automatic logic [31:0] exp_addr(input int k, input logic [31:0] a);
		return (k == 2) ? a + 32'h0000_0040 : (k == 1) ? a + 32'h0000_0010 : a;
	endfunction

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic rd(input logic [2:0] s, input logic [31:0] exp);
		pipe.mv(1'b0, 1'b1, s, 32'h0000_0000, 1'b0);
		#1;
		chk("read valid", 32'h0000_0001, {31'h0, rv});
		chk("read data", exp, rdata);
	endtask

	task automatic final_report;
		if (mismatches == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			final_report();
		end
	end

	initial begin
		logic [31:0] d, a, e, cur;
		logic [1:0] isa;
		int k;
		repeat (10) @(posedge clk_sys);
		reset <= 1'b0;
		rd(drl_pkg::SEL_USER_TRACE, drl_pkg::UTD_RESET);
		for (int i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			d = seed;
			pipe.mv(1'b1, 1'b0, drl_pkg::SEL_RESUME, d, 1'b0);
			#1;
			chk("mode field", {31'h0, d[0]}, {30'h0, fisa});
			rd(drl_pkg::SEL_RESUME, d);
			k = i % 3;
			a = {seed[31:8], 8'h00};
			isa = seed[5:4];
			// a debug interrupt ignores the slot input, so drive it randomly there
			pipe.exc(k == 2, k == 1 || (k == 2 && seed[2]), a, isa);
			#1;
			e = exp_addr(k, a);
			chk("delay flag", {31'h0, k == 1}, {31'h0, bd});
			chk("debug mode", 32'h0000_0001, {31'h0, dm});
			rd(drl_pkg::SEL_RESUME, {e[31:1], isa[0]});
			seed = lfsr(seed);
			d = seed;
			if (i % 2 == 0) begin
				pipe.mv(1'b0, 1'b0, drl_pkg::SEL_RESUME, d, 1'b1);
				cur = {e[31:1], isa[0]};
			end else begin
				// odd passes write together with the return or one move ahead of it
				if (i % 4 == 3) begin
					pipe.mv(1'b1, 1'b0, drl_pkg::SEL_RESUME, d, 1'b0);
				end
				pipe.mv(i % 4 == 1, 1'b0, drl_pkg::SEL_RESUME, d, 1'b1);
				e = {d[31:1], 1'b0};
				isa = {1'b0, d[0]};
				cur = d;
			end
			#1;
			chk("return valid", 32'h0000_0001, {31'h0, tv});
			chk("return target", e, tgt);
			chk("return mode", {30'h0, isa}, {30'h0, risa});
			chk("debug mode", 32'h0000_0000, {31'h0, dm});
			pipe.mv(1'b0, 1'b0, drl_pkg::SEL_RESUME, d, 1'b1);
			#1;
			chk("stray return", 32'h0000_0000, {31'h0, tv});
		end
		pipe.mv(1'b1, 1'b0, 3'h1, seed, 1'b0);
		rd(3'h1, 32'h0000_0000);
		// a foreign register number must not take a write, and a read of it returns zero data
		@(posedge clk_sys);
		mreg <= 5'h17;
		pipe.mv(1'b1, 1'b0, drl_pkg::SEL_RESUME, ~cur, 1'b0);
		rd(drl_pkg::SEL_RESUME, 32'h0000_0000);
		@(posedge clk_sys);
		mreg <= drl_pkg::CP0_REG_DEBUG;
		rd(drl_pkg::SEL_RESUME, cur);
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			@(posedge clk_sys);
			uts <= i[0];
			pipe.mv(1'b1, 1'b0, drl_pkg::SEL_USER_TRACE, seed, 1'b0);
			#1;
			chk("record valid", 32'h0000_0001, {31'h0, pv});
			chk("record type", i[0] ? 32'h0000_0002 : 32'h0000_0001, {30'h0, pt});
			chk("record data", seed, pd);
			rd(drl_pkg::SEL_USER_TRACE, seed);
		end
		final_report();
	end
endmodule
